// >>> rtl/ssc_capture.sv
// source synchronous capture front end: probes, edges, groups, store
// assumes probes, qualifiers and data are asynchronous pins; no bus
//
// Overview of operation
// - edge detector zero is the heartbeat
// - four detectors, any probe edge combination
// - three clock groups complete on member edges
// - four sample clocks, or of qualified terms
// - sample clock zero decides storing
// - per channel group detector, window, group, delay
// - delay each group by programmed heartbeat cycles
// - same inputs captured twice as demux pair
// - per channel two-way or four-way demux select
// - wait for group done before clocking
// - straddling strobe sample taken next heartbeat
// - common window centred, strobe window offset
// - data strobe captured on both edges
// - cs low ras high cas low we high reads
// - cs low ras high cas low we low writes
// - normal mode stores requested channel data
// - glitch storage only under internal clocking
// - glitch trigger independent of glitch storage
// - strobe data synchronised then latched
`default_nettype none
module ssc_capture (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // probe pins
    input wire logic [ssc_pkg::NUM_PROBE-1:0] clock_probe,
    input wire logic [ssc_pkg::NUM_QUAL-1:0] qualifier_input,
    input wire logic [ssc_pkg::NUM_CHGRP*ssc_pkg::GRP_W-1:0] chan_in,
    // edge detector setup: per detector, rise mask then fall mask
    input wire logic [ssc_pkg::NUM_EDGE*2*ssc_pkg::NUM_PROBE-1:0] ed_sel,
    input wire logic [ssc_pkg::NUM_EDGE-1:0] ed_enable,
    // clock group membership, one detector mask per group
    input wire logic [ssc_pkg::NUM_CGRP*ssc_pkg::NUM_EDGE-1:0] cg_member,
    // sample clock terms: group index, use, qualifier use and invert
    input wire logic [ssc_pkg::NUM_SCLK*ssc_pkg::NUM_TERM*2-1:0] sc_grp,
    input wire logic [ssc_pkg::NUM_SCLK*ssc_pkg::NUM_TERM-1:0] sc_use,
    input wire logic [ssc_pkg::NUM_SCLK*ssc_pkg::NUM_TERM*3-1:0] sc_qen,
    input wire logic [ssc_pkg::NUM_SCLK*ssc_pkg::NUM_TERM*3-1:0] sc_qinv,
    // per channel group clocking
    input wire logic [ssc_pkg::NUM_CHGRP*2-1:0] grp_edge,
    input wire logic [ssc_pkg::NUM_CHGRP*2-1:0] grp_cgrp,
    input wire logic [ssc_pkg::NUM_CHGRP*ssc_pkg::DLY_W-1:0] grp_delay,
    input wire logic [ssc_pkg::NUM_CHGRP*ssc_pkg::POS_W-1:0] grp_pos,
    input wire logic [ssc_pkg::NUM_CHGRP*2-1:0] grp_sclk,
    input wire logic [ssc_pkg::NUM_CHGRP-1:0] grp_pair,
    // demux per channel of group zero and global mode
    input wire logic [1:0] demux_type,
    input wire logic [ssc_pkg::GRP_W-1:0] demux_chan,
    input wire logic demux_all,
    input wire logic demux_clear,
    // acquisition control
    input wire logic [1:0] acq_mode,
    input wire logic internal_clocking,
    input wire logic glitch_trig_en,
    input wire logic arm,
    // results
    output logic conflict,
    output logic running,
    output logic glitch_trig,
    output logic [1:0] cmd_code,
    output logic sample_valid,
    input wire logic sample_ready,
    output logic [ssc_pkg::WORD_W-1:0] sample_data
);
    import ssc_pkg::*;

    localparam int CH_W = NUM_CHGRP * GRP_W;
    localparam int NT = NUM_SCLK * NUM_TERM;

    // qualifier term: and of enabled true or inverted qualifiers
    function automatic logic qual_ok(input logic [2:0] en,
                                     input logic [2:0] inv,
                                     input logic [2:0] q);
        qual_ok = &(~en | (q ^ inv));
    endfunction : qual_ok
    // two-flop synchronisers for all pins
    logic [NUM_PROBE-1:0] probe_s1, probe_s2, probe_d;
    logic [NUM_QUAL-1:0] qual_s1, qual_s2;
    logic [CH_W-1:0] chan_s1, chan_s2, chan_d;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            probe_s1 <= '0;
            probe_s2 <= '0;
            probe_d <= '0;
            qual_s1 <= '0;
            qual_s2 <= '0;
            chan_s1 <= '0;
            chan_s2 <= '0;
            chan_d <= '0;
        end else begin
            probe_s1 <= clock_probe;
            probe_s2 <= probe_s1;
            probe_d <= probe_s2;
            qual_s1 <= qualifier_input;
            qual_s2 <= qual_s1;
            chan_s1 <= chan_in;
            chan_s2 <= chan_s1;
            chan_d <= chan_s2;
        end
    end
    // probe edges found on the synchronised copy only
    wire [NUM_PROBE-1:0] rise = probe_s2 & ~probe_d;
    wire [NUM_PROBE-1:0] fall = ~probe_s2 & probe_d;
    // edge detectors: any rise/fall combination per probe
    logic [NUM_EDGE-1:0] ed_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EDGE; gi++) begin : g_ed
            wire [NUM_PROBE-1:0] rm = ed_sel[gi*8 +: 4];
            wire [NUM_PROBE-1:0] fm = ed_sel[gi*8+4 +: 4];
            assign ed_hit[gi] = ed_enable[gi] &&
                                (|(rm & rise) || |(fm & fall));
        end
    endgenerate
    wire heartbeat = ed_hit[HEART_ED];
    wire strobe_edge = ed_hit[STROBE_ED];
    // clock groups: collect member edges, done once all seen
    logic [NUM_EDGE-1:0] cg_seen [NUM_CGRP];
    logic [NUM_CGRP-1:0] cg_done;
    generate
        for (gi = 0; gi < NUM_CGRP; gi++) begin : g_cg
            wire [NUM_EDGE-1:0] mem_m = cg_member[gi*4 +: 4];
            wire [NUM_EDGE-1:0] acc = cg_seen[gi] | (ed_hit & mem_m);
            // non-heartbeat members must be seen; heartbeat closes
            wire all_in = (mem_m != '0) &&
                          ((acc | 4'h1) & mem_m) == mem_m;
            // a strobe landing after the heartbeat carries over
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cg_seen[gi] <= '0;
                    cg_done[gi] <= 1'b0;
                end else if (heartbeat) begin
                    cg_done[gi] <= all_in;
                    cg_seen[gi] <= all_in ? '0 : acc;
                end else begin
                    cg_done[gi] <= 1'b0;
                    cg_seen[gi] <= acc;
                end
            end
        end
    endgenerate
    // sample clock equations: or of qualified clock-group terms
    logic [NUM_SCLK-1:0] sclk;
    logic [NT-1:0] term;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_term
            wire [1:0] gsel = sc_grp[gi*2 +: 2];
            wire gok = (gsel < 2'(NUM_CGRP)) && cg_done[gsel];
            assign term[gi] = sc_use[gi] && gok &&
                qual_ok(sc_qen[gi*3 +: 3], sc_qinv[gi*3 +: 3],
                        qual_s2);
        end
        for (gi = 0; gi < NUM_SCLK; gi++) begin : g_sc
            assign sclk[gi] = |term[gi*NUM_TERM +: NUM_TERM];
        end
    endgenerate
    // strobe data latched on both strobe edges at chosen position
    logic [CH_W-1:0] strobe_hold;
    logic [CH_W-1:0] strobe_late;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobe_hold <= '0;
            strobe_late <= '0;
        end else begin
            strobe_late <= chan_s2;
            if (strobe_edge) strobe_hold <= chan_s2;
        end
    end

    // per group source by edge detector and sampling position
    logic [CH_W-1:0] grp_src;
    logic [CH_W-1:0] dly_line [MAX_DLY+1];
    logic [CH_W-1:0] grp_aligned;
    logic [NUM_CHGRP-1:0] grp_fire;
    generate
        for (gi = 0; gi < NUM_CHGRP; gi++) begin : g_grp
            wire [1:0] pos = grp_pos[gi*2 +: 2];
            wire strobe_grp = grp_edge[gi*2 +: 2] == 2'(STROBE_ED);
            // common clock uses centred window; strobe group shifts
            wire [GRP_W-1:0] early = chan_d[gi*8 +: 8];
            wire [GRP_W-1:0] late = strobe_late[gi*8 +: 8];
            wire [GRP_W-1:0] cen = chan_s2[gi*8 +: 8];
            assign grp_src[gi*8 +: 8] = !strobe_grp ? cen :
                (pos == 2'h0) ? strobe_hold[gi*8 +: 8] :
                (pos == 2'h1) ? early : late;
            wire [DLY_W-1:0] d = grp_delay[gi*3 +: 3];
            assign grp_aligned[gi*8 +: 8] = dly_line[d][gi*8 +: 8];
            wire [1:0] s = grp_sclk[gi*2 +: 2];
            wire [1:0] c = grp_cgrp[gi*2 +: 2];
            assign grp_fire[gi] = sclk[s] &&
                (c < 2'(NUM_CGRP)) && cg_done[c];
        end
    endgenerate
    // delay line advanced by each heartbeat
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i <= MAX_DLY; i++) dly_line[i] <= '0;
        end else if (heartbeat) begin
            dly_line[0] <= grp_src;
            for (int i = 1; i <= MAX_DLY; i++)
                dly_line[i] <= dly_line[i-1];
        end
    end
    // demux pair: paired group takes the partner group's inputs
    logic [CH_W-1:0] paired;
    generate
        for (gi = 0; gi < NUM_CHGRP; gi++) begin : g_pair
            localparam int P = gi ^ 1;
            assign paired[gi*8 +: 8] = grp_pair[gi] ?
                grp_aligned[P*8 +: 8] : grp_aligned[gi*8 +: 8];
        end
    endgenerate

    // probe demux channel selection with select/clear all
    logic [GRP_W-1:0] dmx_sel;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) dmx_sel <= '0;
        else if (demux_clear) dmx_sel <= '0;
        else if (demux_all) dmx_sel <= '1;
        else dmx_sel <= demux_chan;
    end
    wire [1:0] dmx_wrap = (demux_type == DMX_4X) ? 2'h3 : 2'h1;
    // a demuxed source channel of group zero feeds its destinations
    logic [CH_W-1:0] demuxed;
    generate
        for (gi = 0; gi < GRP_W; gi++) begin : g_dmx
            wire on = dmx_sel[gi] && demux_type != DMX_NONE;
            for (genvar k = 0; k < NUM_CHGRP; k++) begin : g_k
                assign demuxed[k*8+gi] = (on && k != 0) ?
                    ((2'(k) <= dmx_wrap) ? paired[gi] :
                     paired[k*8+gi]) : paired[k*8+gi];
            end
        end
    endgenerate
    // command decode from qualifiers: cs=q0 ras=q1 cas=q2 we=probe2
    wire cs_l = qual_s2[0];
    wire ras = qual_s2[1];
    wire cas_l = qual_s2[2];
    wire we = probe_s2[2];
    wire is_read = !cs_l && ras && !cas_l && we;
    wire is_write = !cs_l && ras && !cas_l && !we;
    // glitch: channel changed between samples of one heartbeat
    logic [CH_W-1:0] glitch_acc;
    wire any_glitch = |glitch_acc;
    wire store_glitch = acq_mode == ACQ_GLITCH && internal_clocking;

    // configuration check: reference to unassigned detector or group
    logic cfg_bad;
    always_comb begin
        cfg_bad = 1'b0;
        for (int i = 0; i < NUM_CHGRP; i++) begin
            if (!ed_enable[grp_edge[i*2 +: 2]]) cfg_bad = 1'b1;
            if (grp_cgrp[i*2 +: 2] >= 2'(NUM_CGRP)) cfg_bad = 1'b1;
            else if (cg_member[grp_cgrp[i*2 +: 2]*4 +: 4] == '0)
                cfg_bad = 1'b1;
        end
    end

    // capture state machine clocked by heartbeat qualified events
    ssc_csm_type state, next_state;
    wire fifo_ready;
    wire store_now = sclk[MASTER_SC] && (|grp_fire);
    always_comb begin
        next_state = state;
        unique case (state)
            CSM_IDLE: if (arm && !cfg_bad) next_state = CSM_WAIT;
            CSM_WAIT: if (!arm) next_state = CSM_IDLE;
                else if (store_now && fifo_ready)
                    next_state = CSM_STORE;
            CSM_STORE: next_state = arm ? CSM_WAIT : CSM_IDLE;
        endcase
    end
    wire push = state == CSM_STORE;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] word_q;
    assign word = store_glitch ? {glitch_acc, demuxed} :
                  {{CH_W{1'b0}}, demuxed};

    // state, sample word and status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= CSM_IDLE;
            word_q <= '0;
            conflict <= 1'b0;
            running <= 1'b0;
            glitch_trig <= 1'b0;
            cmd_code <= CMD_OTHER;
            glitch_acc <= '0;
        end else begin
            state <= next_state;
            if (state == CSM_WAIT && next_state == CSM_STORE)
                word_q <= word;
            conflict <= cfg_bad && state == CSM_IDLE;
            running <= next_state != CSM_IDLE;
            glitch_trig <= glitch_trig_en && any_glitch;
            cmd_code <= is_read ? CMD_READ :
                        is_write ? CMD_WRITE : CMD_OTHER;
            glitch_acc <= heartbeat ? '0 :
                          glitch_acc | (chan_s2 ^ chan_d);
        end
    end

    // output buffer; full fifo stalls the state machine
    logic [WORD_W-1:0] fifo_out;
    logic fifo_valid;
    // valid must not wait on ready, or a stalled reader sees nothing
    wire out_free = sample_ready || !sample_valid;
    ssc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(word_q),
        .out_valid(fifo_valid),
        .out_ready(out_free),
        .out_data(fifo_out)
    );
    // output register stage so ports come from flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid <= 1'b0;
            sample_data <= '0;
        end else if (fifo_valid && out_free) begin
            sample_valid <= 1'b1;
            sample_data <= fifo_out;
        end else if (sample_ready) begin
            sample_valid <= 1'b0;
        end
    end

    // checks
    a_store_fires: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == CSM_STORE |-> $past(store_now))
        else $error("store without master sample clock");
    a_conflict_idle: assert property (@(posedge clk_sys)
        disable iff (!rst_n) conflict |-> $past(state) == CSM_IDLE)
        else $error("conflict outside idle");
    a_done_on_hb: assert property (@(posedge clk_sys)
        disable iff (!rst_n) |cg_done |-> $past(heartbeat))
        else $error("group done without heartbeat");
    a_read_decode: assert property (@(posedge clk_sys)
        disable iff (!rst_n) is_read |=> cmd_code == CMD_READ)
        else $error("read not decoded");
    a_write_decode: assert property (@(posedge clk_sys)
        disable iff (!rst_n) is_write |=> cmd_code == CMD_WRITE)
        else $error("write not decoded");
    a_no_glitch: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        push && !$past(store_glitch) |-> word_q[WORD_W-1:CH_W] == '0)
        else $error("glitch bits stored in normal mode");
    a_wait_done: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == CSM_STORE |-> $past(|cg_done))
        else $error("stored before group done");
    a_strobe_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n) strobe_edge |=> strobe_hold == $past(chan_s2))
        else $error("strobe data not latched");
    c_store: cover property (@(posedge clk_sys) push);
    c_read: cover property (@(posedge clk_sys) cmd_code == CMD_READ);
    c_full: cover property (@(posedge clk_sys) !fifo_ready);
endmodule : ssc_capture
`default_nettype wire

// >>> rtl/ssc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes writer and reader share clk_sys
`default_nettype none
module ssc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage
    logic [AW-1:0] wr_ptr;           // write index
    logic [AW-1:0] rd_ptr;           // read index
    logic [AW:0] count;              // fill level
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    // storage written without reset, contents only valid under count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // pointer and level bookkeeping
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
            if (pop) rd_ptr <= AW'(rd_ptr + 1'b1);
            count <= (AW+1)'(count + push - pop);
        end
    end
endmodule : ssc_fifo
`default_nettype wire

// >>> rtl/ssc_pkg.sv
// package for the source synchronous capture front end
// assumes a single system clock of 25 MHz and plain-port configuration
`default_nettype none
package ssc_pkg;
    localparam int NUM_PROBE = 4;       // clock probe inputs
    localparam int NUM_EDGE = 4;        // edge detectors
    localparam int NUM_CGRP = 3;        // clock groups
    localparam int NUM_SCLK = 4;        // sample clocks
    localparam int NUM_TERM = 4;        // or-terms per sample clock
    localparam int NUM_QUAL = 3;        // qualifiers per term
    localparam int NUM_CHGRP = 4;       // channel groups
    localparam int GRP_W = 8;           // channels per group
    localparam int DLY_W = 3;           // pipeline delay field width
    localparam int MAX_DLY = 7;         // deepest pipeline delay
    localparam int POS_W = 2;           // sampling position field width
    localparam int FIFO_DEPTH = 8;      // words in the capture fifo
    localparam int WORD_W = NUM_CHGRP * GRP_W * 2; // data plus glitch
    localparam int HEART_ED = 0;        // heartbeat edge detector
    localparam int STROBE_ED = 1;       // strobe edge detector
    localparam int MASTER_SC = 0;       // master sample clock
    localparam logic [1:0] DMX_NONE = 2'h0; // demux codes
    localparam logic [1:0] DMX_2X = 2'h1;
    localparam logic [1:0] DMX_4X = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h1; // decoded command codes
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_OTHER = 2'h0;
    localparam logic [1:0] ACQ_NORMAL = 2'h0; // acquisition modes
    localparam logic [1:0] ACQ_GLITCH = 2'h1;
    typedef enum logic [1:0] {
        CSM_IDLE, CSM_WAIT, CSM_STORE
    } ssc_csm_type;
endpackage : ssc_pkg
`default_nettype wire

// >>> sim/ssc_target_model.sv
// target bus model: master clock, data strobe, command pins, data
// assumes the bench changes run and data between transfers only, cmd at any time
`default_nettype none
module ssc_target_model (
    // control from the bench
    input wire logic run,
    input wire logic [3:0] cmd,
    input wire logic [31:0] data,
    // pins toward the capture block
    output logic [3:0] clock_probe,
    output logic [2:0] qualifier_input,
    output logic [31:0] chan_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic heart = 1'b0; // target master clock
    logic strobe = 1'b0; // data strobe
    // master clock of 320 ns, standing still between transfers
    always begin
        #160;
        heart = run ? ~heart : 1'b0;
    end
    // strobe edges a quarter period off the master clock edges,
    // so group completion never dithers and the pipeline never overruns
    always @(heart) begin
        #80;
        strobe = run ? ~strobe : 1'b0;
    end
    // cmd is {we, cas, ras, cs}; we rides on the third clock probe
    assign clock_probe = {1'b0, cmd[3], strobe, heart};
    assign qualifier_input = cmd[2:0];
    // a released data bus shows the inverse, never a stale copy
    assign chan_in = run ? data : ~data;
endmodule : ssc_target_model
`default_nettype wire

// >>> sim/tb_source_sync_capture.sv
// self-checking bench for the source synchronous capture front end
// assumes the target model on the probe pins and a 25 MHz clock
`default_nettype none
module tb_source_sync_capture;
    timeunit 1ns;
    timeprecision 1ps;
    import ssc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    // target model control
    logic run = 1'b0;
    logic [3:0] cmd = 4'hb;
    logic [31:0] data = 32'h0000_0000;
    logic [3:0] clock_probe;
    logic [2:0] qualifier_input;
    logic [31:0] chan_in;
    // master clock rise and strobe both edges; group zero of both
    logic [31:0] ed_sel = 32'h0000_2201;
    logic [3:0] ed_enable = 4'h3;
    logic [11:0] cg_member = 12'h003;
    logic [31:0] sc_grp = 32'h0000_0000;
    logic [15:0] sc_use = 16'h0001;
    // term zero: select low, row strobe high, column strobe low
    logic [47:0] sc_qen = 48'h0000_0000_0007;
    logic [47:0] sc_qinv = 48'h0000_0000_0005;
    logic [7:0] grp_edge = 8'h00, grp_cgrp = 8'h00;
    logic [7:0] grp_pos = 8'h00, grp_sclk = 8'h00;
    logic [11:0] grp_delay = 12'h000;
    logic [3:0] grp_pair = 4'h0;
    logic [1:0] acq_mode = ACQ_NORMAL;
    logic internal_clocking = 1'b0;
    logic arm = 1'b0;
    logic glitch_trig_en = 1'b0;
    logic [1:0] demux_type = DMX_NONE;
    logic [7:0] demux_chan = 8'h00;
    logic demux_clear = 1'b1;
    logic sample_ready = 1'b0;
    logic conflict, running, glitch_trig, sample_valid;
    logic [1:0] cmd_code;
    logic [WORD_W-1:0] sample_data;
    int err_count = 0;
    int n_checks = 0;
    int i, cnt;
    // rows: {we, cas, ras, cs} beside the decoded command
    logic [3:0] row_in [6] = '{4'h0a, 4'h02, 4'h0e, 4'h0b, 4'h08, 4'h06};
    logic [1:0] row_out [6] = '{CMD_READ, CMD_WRITE, CMD_OTHER,
        CMD_OTHER, CMD_OTHER, CMD_OTHER};
    // free running system clock
    always #20 clk_sys = ~clk_sys;
    ssc_target_model u_tgt (.run(run), .cmd(cmd), .data(data),
        .clock_probe(clock_probe), .qualifier_input(qualifier_input),
        .chan_in(chan_in));
    ssc_capture u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .clock_probe(clock_probe), .qualifier_input(qualifier_input),
        .chan_in(chan_in), .ed_sel(ed_sel), .ed_enable(ed_enable),
        .cg_member(cg_member), .sc_grp(sc_grp), .sc_use(sc_use),
        .sc_qen(sc_qen), .sc_qinv(sc_qinv), .grp_edge(grp_edge),
        .grp_cgrp(grp_cgrp), .grp_delay(grp_delay), .grp_pos(grp_pos),
        .grp_sclk(grp_sclk), .grp_pair(grp_pair), .demux_type(demux_type),
        .demux_chan(demux_chan), .demux_all(1'b0), .demux_clear(demux_clear),
        .acq_mode(acq_mode), .internal_clocking(internal_clocking),
        .glitch_trig_en(glitch_trig_en), .arm(arm), .conflict(conflict),
        .running(running), .glitch_trig(glitch_trig),
        .cmd_code(cmd_code), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data));
    // compare of a single flag
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit
    // compare of a whole word
    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    // inputs always move 2 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : cyc
    // verdict and end of run
    task automatic results;
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    // hang guard, far beyond the roughly 650 cycles of the tests
    initial begin
        #800_000;
        err_count++;
        results();
    end
    // main sequence
    initial begin
        cyc(12);
        rst_n = 1'b1;
        run = 1'b1;
        sample_ready = 1'b1;
        // decode table, four master clocks a row, not armed
        for (i = 0; i < 6; i++) begin
            cmd = row_in[i];
            cyc(32);
            chk_word({62'h0, cmd_code}, {62'h0, row_out[i]});
            chk_bit(sample_valid, 1'b0);
        end
        run = 1'b0;
        // group zero on a disabled detector, then on an empty group
        grp_edge = 8'h02;
        cyc(4);
        chk_bit(conflict, 1'b1);
        arm = 1'b1;
        cyc(8);
        chk_bit(running, 1'b0);
        arm = 1'b0;
        grp_edge = 8'h00;
        grp_cgrp = 8'h01;
        cyc(4);
        chk_bit(conflict, 1'b1);
        grp_cgrp = 8'h00;
        cyc(4);
        chk_bit(conflict, 1'b0);
        // read bursts with the reader stalled until the fifo refuses
        sample_ready = 1'b0;
        cmd = 4'h0a;
        data = 32'ha5c3_0f96;
        arm = 1'b1;
        cyc(4);
        chk_bit(running, 1'b1);
        run = 1'b1;
        cyc(200);
        run = 1'b0;
        chk_bit(sample_valid, 1'b1);
        // drain; every word is the data with no glitch half
        sample_ready = 1'b1;
        cnt = 0;
        while (sample_valid === 1'b1 && cnt < 40) begin
            chk_word(sample_data, {32'h0000_0000, data});
            cnt++;
            cyc(1);
        end
        chk_bit(cnt >= FIFO_DEPTH, 1'b1);
        // column strobe high: sample clock zero stays false
        cmd = 4'h0e;
        run = 1'b1;
        cyc(120);
        run = 1'b0;
        chk_bit(sample_valid, 1'b0);
        // glitch mode without internal clocking stores no glitch half
        sample_ready = 1'b0;
        acq_mode = ACQ_GLITCH;
        cmd = 4'h02;
        data = 32'h5a3c_f069;
        // two-way demux: low nibble of group zero also feeds group one
        demux_type = DMX_2X;
        demux_chan = 8'h0f;
        demux_clear = 1'b0;
        run = 1'b1;
        cyc(80);
        chk_word(sample_data,
            {32'h0000_0000, data[31:12], data[3:0], data[7:0]});
        // glitch trigger works although glitches are not stored
        run = 1'b0;
        cyc(6);
        data = 32'h0000_0000;
        cyc(6);
        chk_bit(glitch_trig, 1'b0);
        glitch_trig_en = 1'b1;
        cyc(2);
        chk_bit(glitch_trig, 1'b1);
        // reset in mid-run clears the outputs
        rst_n = 1'b0;
        cyc(2);
        chk_bit(sample_valid, 1'b0);
        chk_bit(running, 1'b0);
        rst_n = 1'b1;
        results();
    end
endmodule : tb_source_sync_capture
`default_nettype wire
